// ===== vmcrf_core.sv
// vector coprocessor register file with clear, mode-bit clear and move instructions
//
// Overview of operation
// [RULE1] clear-one zeroes selected working register
// [RULE2] clear-all zeroes registers, transitions, metrics
// [RULE3] clears and half moves take one cycle
// [RULE4] clear complex packing bit; real high
// [RULE5] clear crc message flip bit
// [RULE6] crc message flip bit resets zero
// [RULE7] clear traceback output packing bit
// [RULE8] clear imaginary overflow flag only
// [RULE9] clear real overflow flag only
// [RULE10] half store high when bit12 set
// [RULE11] half store low when bit12 clear
// [RULE12] half load high, keep low
// [RULE13] half load low, keep high
// [RULE14] cpu-to-coproc move, ignore protect bit
// [RULE15] cpu-to-coproc move takes two cycles
// [RULE16] issuer waits four slots before use
// [RULE17] coproc-to-cpu move, two cycles
// [RULE18] register codes above eight write nothing
`include "vmcrf_regs.svh"
module vmcrf_core
    import vmcrf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic protected_write_enable,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic busy
);

    // working registers, transition bits, survivor metrics
    logic [31:0] working_reg_q [0:`VMCRF_NUM_WREGS-1];
    logic [31:0] transition_bits_reg_0_q;
    logic [31:0] transition_bits_reg_1_q;
    logic [31:0] survivor_metric_entry_q [0:`VMCRF_NUM_VSM-1];
    logic [31:0] coproc_status_reg_q;
    vmcrf_instr_type instr_q;
    vmcrf_data_type data_q;
    logic [1:0] evt_stat_q;
    logic [1:0] evt_en_q;
    vmcrf_state_type state_q;
    logic [7:0] move_ctx_q;
    logic [15:0] move_addr_q;

    // apb decode
    wire apb_acc = psel && penable && clk_en;
    wire apb_wr = apb_acc && pwrite;
    wire apb_rd = apb_acc && !pwrite;
    wire wr_instr = apb_wr && (paddr == `VMCRF_OFF_INSTR);
    wire wr_operand = apb_wr && (paddr == `VMCRF_OFF_OPERAND);
    wire wr_evt_clr = apb_wr && (paddr == `VMCRF_OFF_EVT_CLR);
    wire wr_evt_en = apb_wr && (paddr == `VMCRF_OFF_EVT_EN);

    // instruction fields
    wire [15:0] op_lo = pwdata[15:0];
    wire [15:0] op_hi = pwdata[31:16];
    wire [3:0] reg_sel = op_hi[3:0];
    wire [3:0] half_sel_reg = op_hi[11:8];
    wire half_high = op_hi[`VMCRF_HALF_SEL_BIT];
    wire [15:0] mem_operand = data_q.operand[15:0];

    function automatic logic reg_ok(input logic [3:0] sel);
        reg_ok = (sel < 4'(`VMCRF_NUM_WREGS));
    endfunction

    // coprocessor address map for the 32-bit moves: word index into register space
    function automatic logic [31:0] coproc_read(input logic [15:0] a);
        logic [15:0] w;
        w = a - 16'(`VMCRF_OFF_WREG_BASE >> 2);
        coproc_read = 32'h0000_0000;
        if (a >= 16'(`VMCRF_OFF_WREG_BASE >> 2) && w < 16'(`VMCRF_NUM_WREGS))
            coproc_read = working_reg_q[w[3:0]];
        else if (a == 16'(`VMCRF_OFF_VT0 >> 2))
            coproc_read = transition_bits_reg_0_q;
        else if (a == 16'(`VMCRF_OFF_VT1 >> 2))
            coproc_read = transition_bits_reg_1_q;
        else if (a == 16'(`VMCRF_OFF_STATUS >> 2))
            coproc_read = coproc_status_reg_q;
    endfunction

    wire is_clr_one = wr_instr && op_lo == `VMCRF_OP_CLR_ONE;
    wire is_clr_all = wr_instr && op_lo == `VMCRF_OP_CLR_ALL;
    wire is_clr_complex_packing_bit = wr_instr && op_lo == `VMCRF_OP_CLR_COMPLEX_PACKING_BIT;
    wire is_clr_crc = wr_instr && op_lo == `VMCRF_OP_CLR_CRCFLIP;
    wire is_clr_traceback_packing_bit = wr_instr && op_lo == `VMCRF_OP_CLR_TRACEBACK_PACKING_BIT;
    wire is_clr_imaginary_overflow_flag = wr_instr && op_lo == `VMCRF_OP_CLR_IMAGINARY_OVERFLOW_FLAG;
    wire is_clr_real_overflow_flag = wr_instr && op_lo == `VMCRF_OP_CLR_REAL_OVERFLOW_FLAG;
    wire is_hstore = wr_instr && op_lo == `VMCRF_OP_HSTORE;
    wire is_hload = wr_instr && op_lo == `VMCRF_OP_HLOAD;
    wire is_move = wr_instr && (op_lo[15:8] == `VMCRF_OP8_MOVE_TO || op_lo[15:8] == `VMCRF_OP8_MOVE_FROM);
    wire single_op = is_clr_one || is_clr_all || is_clr_complex_packing_bit || is_clr_crc || is_clr_traceback_packing_bit
        || is_clr_imaginary_overflow_flag || is_clr_real_overflow_flag || is_hstore || is_hload;
    wire bad_reg = (is_clr_one && !reg_ok(reg_sel)) || ((is_hstore || is_hload) && !reg_ok(half_sel_reg));
    wire move_done = (state_q == VMCRF_EXEC2) && clk_en;
    wire move_to = move_ctx_q == `VMCRF_OP8_MOVE_TO;
    wire [15:0] mv_w = move_addr_q - 16'(`VMCRF_OFF_WREG_BASE >> 2);
    wire mv_wreg = move_addr_q >= 16'(`VMCRF_OFF_WREG_BASE >> 2) && mv_w < 16'(`VMCRF_NUM_WREGS);
    wire evt_done = single_op || move_done;

    // read mux
    wire [31:0] evt_word = {30'h0000_0000, evt_stat_q};
    wire [31:0] en_word = {30'h0000_0000, evt_en_q};
    wire [11:0] wreg_off = paddr - `VMCRF_OFF_WREG_BASE;
    wire rd_wreg = paddr >= `VMCRF_OFF_WREG_BASE && wreg_off[11:2] < 10'(`VMCRF_NUM_WREGS)
        && paddr[1:0] == 2'b00;
    wire [11:0] vsm_off = paddr - `VMCRF_OFF_VSM_BASE;
    wire rd_vsm = paddr >= `VMCRF_OFF_VSM_BASE && vsm_off[11:2] < 10'(`VMCRF_NUM_VSM) && paddr[1:0] == 2'b00;
    wire known_fixed = paddr == `VMCRF_OFF_INSTR || paddr == `VMCRF_OFF_OPERAND || paddr == `VMCRF_OFF_RESULT
        || paddr == `VMCRF_OFF_STATUS || paddr == `VMCRF_OFF_EVT_STAT || paddr == `VMCRF_OFF_EVT_CLR
        || paddr == `VMCRF_OFF_EVT_EN || paddr == `VMCRF_OFF_VT0 || paddr == `VMCRF_OFF_VT1;
    wire addr_ok = known_fixed || rd_wreg || rd_vsm;
    wire [31:0] rd_mux =
        paddr == `VMCRF_OFF_INSTR ? {instr_q.op_hi, instr_q.op_lo} :
        paddr == `VMCRF_OFF_OPERAND ? data_q.operand :
        paddr == `VMCRF_OFF_RESULT ? data_q.result :
        paddr == `VMCRF_OFF_STATUS ? coproc_status_reg_q :
        paddr == `VMCRF_OFF_EVT_STAT ? evt_word :
        paddr == `VMCRF_OFF_EVT_EN ? en_word :
        paddr == `VMCRF_OFF_VT0 ? transition_bits_reg_0_q :
        paddr == `VMCRF_OFF_VT1 ? transition_bits_reg_1_q :
        rd_wreg ? working_reg_q[wreg_off[5:2]] :
        rd_vsm ? survivor_metric_entry_q[vsm_off[7:2]] : 32'h0000_0000;
    // busy refuses a new instruction while a two-cycle move runs
    wire instr_refused = wr_instr && state_q != VMCRF_IDLE;

    // apb response, zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // working registers and metrics
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `VMCRF_NUM_WREGS; i++)
                working_reg_q[i] <= 32'h0000_0000;
            for (int i = 0; i < `VMCRF_NUM_VSM; i++)
                survivor_metric_entry_q[i] <= 32'h0000_0000;
            transition_bits_reg_0_q <= 32'h0000_0000;
            transition_bits_reg_1_q <= 32'h0000_0000;
        end
        else if (clk_en && !instr_refused)
        begin
            if (is_clr_all)
            begin
                for (int i = 0; i < `VMCRF_NUM_WREGS; i++)
                    working_reg_q[i] <= 32'h0000_0000; // [RULE2]
                for (int i = 0; i < `VMCRF_NUM_VSM; i++)
                    survivor_metric_entry_q[i] <= 32'h0000_0000; // [RULE2]
                transition_bits_reg_0_q <= 32'h0000_0000;
                transition_bits_reg_1_q <= 32'h0000_0000;
            end
            if (is_clr_one && reg_ok(reg_sel)) // [RULE18]
                working_reg_q[reg_sel] <= 32'h0000_0000; // [RULE1]
            if (is_hload && reg_ok(half_sel_reg))
            begin
                if (half_high)
                    working_reg_q[half_sel_reg][31:16] <= mem_operand; // [RULE12]
                else
                    working_reg_q[half_sel_reg][15:0] <= mem_operand; // [RULE13]
            end
            // protect bit deliberately not consulted
            if (move_done && move_to && mv_wreg)
                working_reg_q[mv_w[3:0]] <= data_q.operand; // [RULE14]
            if (move_done && move_to && move_addr_q == 16'(`VMCRF_OFF_VT0 >> 2))
                transition_bits_reg_0_q <= data_q.operand; // [RULE14]
            if (move_done && move_to && move_addr_q == 16'(`VMCRF_OFF_VT1 >> 2))
                transition_bits_reg_1_q <= data_q.operand; // [RULE14]
        end
    end

    // status mode bits and overflow flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            coproc_status_reg_q <= `VMCRF_STATUS_RESET; // [RULE6]
        else if (clk_en && !instr_refused)
        begin
            if (is_clr_complex_packing_bit)
                coproc_status_reg_q[`VMCRF_ST_COMPLEX_PACKING_BIT_BIT] <= 1'b0; // [RULE4]
            if (is_clr_crc)
                coproc_status_reg_q[`VMCRF_ST_CRCFLIP_BIT] <= 1'b0; // [RULE5]
            if (is_clr_traceback_packing_bit)
                coproc_status_reg_q[`VMCRF_ST_TRACEBACK_PACKING_BIT_BIT] <= 1'b0; // [RULE7]
            if (is_clr_imaginary_overflow_flag)
                coproc_status_reg_q[`VMCRF_ST_IMAGINARY_OVERFLOW_FLAG_BIT] <= 1'b0; // [RULE8]
            if (is_clr_real_overflow_flag)
                coproc_status_reg_q[`VMCRF_ST_REAL_OVERFLOW_FLAG_BIT] <= 1'b0; // [RULE9]
            if (move_done && move_to && move_addr_q == 16'(`VMCRF_OFF_STATUS >> 2))
                coproc_status_reg_q <= data_q.operand; // [RULE14]
        end
    end

    // instruction, operand, result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_q <= '0;
            data_q <= '0;
        end
        else if (clk_en)
        begin
            if (wr_instr && !instr_refused)
                instr_q <= vmcrf_instr_type'({op_lo, op_hi});
            if (wr_operand)
                data_q.operand <= pwdata;
            if (is_hstore && !instr_refused && reg_ok(half_sel_reg))
                data_q.result <= {16'h0000, half_high ? working_reg_q[half_sel_reg][31:16] // [RULE10]
                                                      : working_reg_q[half_sel_reg][15:0]}; // [RULE11]
            if (move_done && !move_to)
                data_q.result <= coproc_read(move_addr_q); // [RULE17]
        end
    end

    // two-cycle move sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= VMCRF_IDLE;
            move_ctx_q <= 8'h00;
            move_addr_q <= 16'h0000;
            busy <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_q)
                VMCRF_IDLE:
                begin
                    if (is_move)
                    begin
                        state_q <= VMCRF_EXEC2; // [RULE15]
                        move_ctx_q <= op_lo[15:8];
                        move_addr_q <= op_hi; // [RULE14]
                        busy <= 1'b1;
                    end
                end
                VMCRF_EXEC2:
                begin
                    state_q <= VMCRF_IDLE;
                    busy <= 1'b0;
                end
                default:
                begin
                    state_q <= VMCRF_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // event status, set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_stat_q <= 2'b00;
            evt_en_q <= 2'b00;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            evt_stat_q <= (evt_stat_q & ~(wr_evt_clr ? pwdata[1:0] : 2'b00))
                | {bad_reg && !instr_refused, evt_done && !instr_refused};
            if (wr_evt_en)
                evt_en_q <= pwdata[1:0];
            irq <= |(evt_stat_q & evt_en_q);
        end
    end

    logic past_valid_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            past_valid_q <= 1'b0;
        else
            past_valid_q <= 1'b1;
    end

    a_clr_one_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        (is_clr_one && reg_ok(reg_sel) && !instr_refused && !is_clr_all) |=> working_reg_q[$past(reg_sel)] == 32'h0)
        else $error("clear one left register nonzero");
    a_clr_all_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        (is_clr_all && !instr_refused) |=> working_reg_q[8] == 32'h0 && transition_bits_reg_1_q == 32'h0
            && survivor_metric_entry_q[63] == 32'h0)
        else $error("clear all left state nonzero");
    a_clr_keeps_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        (is_clr_all && !instr_refused) |=> $stable(coproc_status_reg_q))
        else $error("clear all touched status");
    a_complex_packing_bit_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        (is_clr_complex_packing_bit && !instr_refused) |=> !coproc_status_reg_q[`VMCRF_ST_COMPLEX_PACKING_BIT_BIT])
        else $error("packing bit not cleared");
    a_crc_reset: assert property (@(posedge pclk) // [RULE6]
        $rose(presetn) |-> !coproc_status_reg_q[`VMCRF_ST_CRCFLIP_BIT])
        else $error("crc flip bit not zero after reset");
    a_imaginary_overflow_flag_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        (is_clr_imaginary_overflow_flag && !instr_refused && !is_move && state_q == VMCRF_IDLE) |=>
            !coproc_status_reg_q[`VMCRF_ST_IMAGINARY_OVERFLOW_FLAG_BIT]
            && coproc_status_reg_q[`VMCRF_ST_REAL_OVERFLOW_FLAG_BIT] == $past(coproc_status_reg_q[`VMCRF_ST_REAL_OVERFLOW_FLAG_BIT]))
        else $error("imaginary clear wrong");
    a_real_overflow_flag_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        (is_clr_real_overflow_flag && !instr_refused && state_q == VMCRF_IDLE) |=>
            !coproc_status_reg_q[`VMCRF_ST_REAL_OVERFLOW_FLAG_BIT]
            && coproc_status_reg_q[`VMCRF_ST_IMAGINARY_OVERFLOW_FLAG_BIT] == $past(coproc_status_reg_q[`VMCRF_ST_IMAGINARY_OVERFLOW_FLAG_BIT]))
        else $error("real clear wrong");
    a_hload_high: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        (is_hload && half_high && reg_ok(half_sel_reg) && !instr_refused) |=>
            working_reg_q[$past(half_sel_reg)][15:0] == $past(working_reg_q[half_sel_reg][15:0]))
        else $error("high load changed low half");
    a_move_two: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
        (is_move && state_q == VMCRF_IDLE && clk_en) |=> busy ##1 (!busy || !clk_en))
        else $error("move not two cycles");
    c_clr_all: cover property (@(posedge pclk) disable iff (!presetn) is_clr_all);
    c_move: cover property (@(posedge pclk) disable iff (!presetn) move_done && !move_to);
    c_hstore: cover property (@(posedge pclk) disable iff (!presetn) is_hstore && half_high);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

// ===== vmcrf_regs.svh
// register offsets, field positions, opcodes and reset values of the vector register block
`ifndef VMCRF_REGS_SVH
`define VMCRF_REGS_SVH
`define VMCRF_OFF_INSTR 12'h000
`define VMCRF_OFF_OPERAND 12'h004
`define VMCRF_OFF_RESULT 12'h008
`define VMCRF_OFF_STATUS 12'h00C
`define VMCRF_OFF_EVT_STAT 12'h010
`define VMCRF_OFF_EVT_CLR 12'h014
`define VMCRF_OFF_EVT_EN 12'h018
`define VMCRF_OFF_WREG_BASE 12'h040
`define VMCRF_OFF_VT0 12'h064
`define VMCRF_OFF_VT1 12'h068
`define VMCRF_OFF_VSM_BASE 12'h100
`define VMCRF_OP_CLR_ONE 16'hE6F8
`define VMCRF_OP_CLR_ALL 16'hE6F9
`define VMCRF_OP_CLR_COMPLEX_PACKING_BIT 16'hE522
`define VMCRF_OP_CLR_CRCFLIP 16'hE52D
`define VMCRF_OP_CLR_TRACEBACK_PACKING_BIT 16'hE525
`define VMCRF_OP_CLR_IMAGINARY_OVERFLOW_FLAG 16'hE50B
`define VMCRF_OP_CLR_REAL_OVERFLOW_FLAG 16'hE50A
`define VMCRF_OP_HSTORE 16'hE218
`define VMCRF_OP_HLOAD 16'hE2C9
`define VMCRF_OP8_MOVE_TO 8'hBD
`define VMCRF_OP8_MOVE_FROM 8'hBF
`define VMCRF_HALF_SEL_BIT 12
`define VMCRF_ST_REAL_OVERFLOW_FLAG_BIT 0
`define VMCRF_ST_IMAGINARY_OVERFLOW_FLAG_BIT 1
`define VMCRF_ST_COMPLEX_PACKING_BIT_BIT 2
`define VMCRF_ST_CRCFLIP_BIT 3
`define VMCRF_ST_TRACEBACK_PACKING_BIT_BIT 4
`define VMCRF_STATUS_RESET 32'h0000_0000
`define VMCRF_EVT_DONE_BIT 0
`define VMCRF_EVT_BADREG_BIT 1
`define VMCRF_NUM_WREGS 9
`define VMCRF_NUM_VSM 64
`define VMCRF_TWO_CYCLE_WAIT 1
`endif

// ===== vmcrf_pkg.sv
// types shared by the vector register block
package vmcrf_pkg;
    typedef enum logic [1:0] {
        VMCRF_IDLE = 2'b00,
        VMCRF_EXEC2 = 2'b01
    } vmcrf_state_type;
    typedef struct packed {
        logic [15:0] op_lo;
        logic [15:0] op_hi;
    } vmcrf_instr_type;
    typedef struct packed {
        logic [31:0] operand;
        logic [31:0] result;
    } vmcrf_data_type;
endpackage

// ===== vmcrf_host_model.sv
// host pipeline model issuing instructions over the register bus
`include "vmcrf_regs.svh"
module vmcrf_host_model
    import vmcrf_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic b1;
    logic b2;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // one transfer, entered right after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // operand then instruction; busy seen in the two cycles after
    task automatic exec(input logic [31:0] ins, input logic [31:0] opd);
        logic [31:0] rd;
        logic er;
        xfer(1'b1, `VMCRF_OFF_OPERAND, opd, rd, er);
        xfer(1'b1, `VMCRF_OFF_INSTR, ins, rd, er);
        b1 = busy;
        @(posedge pclk);
        b2 = busy;
        if (ins[15:8] == `VMCRF_OP8_MOVE_TO)
            repeat (3) @(posedge pclk);
    endtask
endmodule

// ===== testbench.sv
// self-checking bench for the vector register block
`include "vmcrf_regs.svh"
module testbench
    import vmcrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, clk_en, psel, penable, pwrite, protected_write_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, st;
    logic pready, pslverr, irq, busy, er;
    logic [31:0] mdl [0:8];
    logic [15:0] v;
    logic [15:0] mops [0:4];
    int mbit [0:4];
    int errors = 0;
    int check_count = 0;
    integer seed = 32'hC84036B4;
    vmcrf_core i_vmcrf_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .protected_write_enable(protected_write_enable), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .busy(busy));
    vmcrf_host_model i_vmcrf_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rd32(input logic [11:0] a, output logic [31:0] d);
        i_vmcrf_host_model.xfer(1'b0, a, 32'h0000_0000, d, er);
    endtask
    task automatic chk_regs(input string msg);
        for (int i = 0; i < 9; i++)
        begin
            rd32(`VMCRF_OFF_WREG_BASE + 12'(4 * i), rd);
            cmp(rd, mdl[i], msg);
        end
    endtask
    task automatic mv_to(input logic [15:0] wa, input logic [31:0] d);
        protected_write_enable <= 1'($random(seed));
        i_vmcrf_host_model.exec({wa, `VMCRF_OP8_MOVE_TO, 8'h00}, d);
        cmp({31'h0, i_vmcrf_host_model.b1}, 32'h1, "move busy");
        cmp({31'h0, i_vmcrf_host_model.b2}, 32'h0, "move two cycles");
    endtask
    task automatic op1(input logic [31:0] ins, input logic [31:0] d);
        i_vmcrf_host_model.exec(ins, d);
        cmp({31'h0, i_vmcrf_host_model.b1}, 32'h0, "single cycle");
    endtask
    function automatic logic [31:0] f_half(input logic [31:0] o, input logic hi, input logic [15:0] d);
        return hi ? {d, o[15:0]} : {o[31:16], d};
    endfunction
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end
    initial
    begin
        presetn = 1'b0;
        clk_en = 1'b1;
        protected_write_enable = 1'b0;
        mops = '{`VMCRF_OP_CLR_COMPLEX_PACKING_BIT, `VMCRF_OP_CLR_CRCFLIP, `VMCRF_OP_CLR_TRACEBACK_PACKING_BIT,
                 `VMCRF_OP_CLR_IMAGINARY_OVERFLOW_FLAG, `VMCRF_OP_CLR_REAL_OVERFLOW_FLAG};
        mbit = '{2, 3, 4, 1, 0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd32(`VMCRF_OFF_STATUS, rd);
        cmp(rd, 32'h0000_0000, "status after reset");
        for (int i = 0; i < 9; i++)
            mdl[i] = 32'h0000_0000;
        chk_regs("regs after reset");
        $display("test reset done");
        for (int i = 0; i < 9; i++)
        begin
            mdl[i] = $random(seed);
            mv_to(16'h0010 + 16'(i), mdl[i]);
        end
        chk_regs("move to coproc");
        for (int i = 0; i < 9; i++)
        begin
            i_vmcrf_host_model.exec({16'h0010 + 16'(i), `VMCRF_OP8_MOVE_FROM, 8'h00}, 32'h0);
            cmp({31'h0, i_vmcrf_host_model.b2}, 32'h0, "move from two cycles");
            rd32(`VMCRF_OFF_RESULT, rd);
            cmp(rd, mdl[i], "move from coproc");
        end
        rd32(`VMCRF_OFF_STATUS, rd);
        cmp(rd, 32'h0000_0000, "flags after moves");
        $display("test full moves done");
        for (int k = 0; k < 18; k++)
        begin
            v = 16'($random(seed));
            op1({3'b000, k[0], 4'(k / 2), 8'h00, `VMCRF_OP_HLOAD}, {16'h0000, v});
            mdl[k / 2] = f_half(mdl[k / 2], k[0], v);
            op1({3'b000, k[0], 4'(k / 2), 8'h00, `VMCRF_OP_HSTORE}, 32'h0);
            rd32(`VMCRF_OFF_RESULT, rd);
            v = k[0] ? mdl[k / 2][31:16] : mdl[k / 2][15:0];
            cmp(rd, {16'h0000, v}, "half store");
        end
        chk_regs("half loads");
        $display("test half moves done");
        st = 32'h0000_001F;
        mv_to(16'h0003, st);
        for (int j = 0; j < 5; j++)
        begin
            op1({16'h0000, mops[j]}, 32'h0);
            st[mbit[j]] = 1'b0;
            rd32(`VMCRF_OFF_STATUS, rd);
            cmp(rd, st, "mode clear");
        end
        $display("test mode bits done");
        st = 32'h0000_001F;
        mv_to(16'h0003, st);
        mv_to(16'h0019, 32'hA5A5_5A5A);
        mv_to(16'h001A, 32'h0F0F_F0F0);
        wr32(`VMCRF_OFF_EVT_CLR, 32'h0000_0003);
        for (int c = 9; c < 16; c++)
            op1({12'h000, 4'(c), `VMCRF_OP_CLR_ONE}, 32'h0);
        chk_regs("reserved select");
        rd32(`VMCRF_OFF_EVT_STAT, rd);
        cmp(rd & 32'h2, 32'h0000_0002, "bad register event");
        op1({12'h000, 4'h8, `VMCRF_OP_CLR_ONE}, 32'h0);
        mdl[8] = 32'h0000_0000;
        chk_regs("clear one");
        rd32(`VMCRF_OFF_STATUS, rd);
        cmp(rd, st, "flags after clear one");
        op1({16'h0000, `VMCRF_OP_CLR_ALL}, 32'h0);
        for (int i = 0; i < 9; i++)
            mdl[i] = 32'h0000_0000;
        chk_regs("clear all");
        foreach (mops[j])
        begin
            rd32(j == 0 ? `VMCRF_OFF_VT0 : j == 1 ? `VMCRF_OFF_VT1 : `VMCRF_OFF_VSM_BASE + 12'(j * 60), rd);
            cmp(rd, 32'h0000_0000, "transition and metric clear");
        end
        rd32(`VMCRF_OFF_STATUS, rd);
        cmp(rd, st, "flags after clear all");
        $display("test clears done");
        wr32(`VMCRF_OFF_EVT_EN, 32'h0000_0000);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h0, "irq masked");
        wr32(`VMCRF_OFF_EVT_EN, 32'h0000_0003);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h1, "irq raised");
        wr32(`VMCRF_OFF_EVT_CLR, 32'h0000_0003);
        @(posedge pclk);
        cmp({31'h0, irq}, 32'h0, "irq cleared");
        rd32(`VMCRF_OFF_EVT_STAT, rd);
        cmp(rd, 32'h0000_0000, "events cleared");
        i_vmcrf_host_model.xfer(1'b0, 12'hFFC, 32'h0, rd, er);
        cmp({31'h0, er}, 32'h1, "unmapped error");
        $display("test interrupt and bus done");
        print_verdict();
    end
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        i_vmcrf_host_model.xfer(1'b1, a, d, r, e);
    endtask
endmodule
